// ---- src/crfd_consts.vh ----
// Constants for the core register file and instruction field decoder.
// Assumes a single core clock and a pipeline that issues decoded strobes.
//
// Operation
// - Register words split into opcode, source, target, dest, shift, function.
// - Immediate words present bits 15:0 as a signed 16-bit immediate.
// - Jump words shift the 26-bit index left two for the low 28 bits.
// - Thirty-two 32-bit general registers, selected by 5-bit specifiers.
// - Reads of the zero register always return zero.
// - Writes aimed at the zero register are discarded, no state changes.
// - Link instructions write the return address into register 31 implicitly.
// - Multiply puts high product word in high, low word in low.
// - Multiply-add and multiply-subtract update the high/low pair in place.
// - Divide puts quotient in low and remainder in high.
// - Multiply-accumulate keeps the running result in the high/low pair.
// - Program counter is hidden; changes only by sequencing and transfers.
`ifndef CRFD_CONSTS_VH
`define CRFD_CONSTS_VH

// ============================================================
// Instruction field positions
`define CRFD_OPC_MSB 31
`define CRFD_OPC_LSB 26
`define CRFD_SRC_MSB 25
`define CRFD_SRC_LSB 21
`define CRFD_TGT_MSB 20
`define CRFD_TGT_LSB 16
`define CRFD_DST_MSB 15
`define CRFD_DST_LSB 11
`define CRFD_SHA_MSB 10
`define CRFD_SHA_LSB 6
`define CRFD_FUN_MSB 5
`define CRFD_FUN_LSB 0
`define CRFD_IMM_MSB 15
`define CRFD_IMM_LSB 0
`define CRFD_IDX_MSB 25
`define CRFD_IDX_LSB 0

// ============================================================
// Fixed register numbers
`define CRFD_ZERO_REG 5'h00
`define CRFD_LINK_REG 5'h1F

// ============================================================
// Multiply/divide commands
`define CRFD_MD_NONE 4'h0
`define CRFD_MD_MULT 4'h1
`define CRFD_MD_MULTU 4'h2
`define CRFD_MD_MADD 4'h3
`define CRFD_MD_MADDU 4'h4
`define CRFD_MD_MSUB 4'h5
`define CRFD_MD_MSUBU 4'h6
`define CRFD_MD_DIV 4'h7
`define CRFD_MD_DIVU 4'h8

// ============================================================
// Program counter controls
`define CRFD_PC_HOLD 3'h0
`define CRFD_PC_SEQ 3'h1
`define CRFD_PC_JUMP 3'h2
`define CRFD_PC_BRANCH 3'h3
`define CRFD_PC_REG 3'h4

// ============================================================
// Reset values and step sizes
`define CRFD_PC_RESET 32'h00000000
`define CRFD_PC_STEP 32'h00000004
`define CRFD_LINK_OFS 32'h00000008
`define CRFD_WORD_RESET 32'h00000000

`endif

// ---- src/crfd_decode.v ----
// Combinational instruction field extraction for all three formats.
// Assumes the caller registers the results.
`timescale 1ns/1ns
`default_nettype none
`include "crfd_consts.vh"

module crfd_decode (
  input wire [31:0] instr_word,
  output wire [5:0] opcode,
  output wire [4:0] source_reg_field,
  output wire [4:0] target_reg_field,
  output wire [4:0] dest_reg_field,
  output wire [4:0] shift_amount_field,
  output wire [5:0] function_code,
  output wire [31:0] imm_sext,
  output wire [27:0] jump_low_addr
);

  wire [15:0] imm_raw;
  wire [25:0] jump_index_field;

  assign opcode = instr_word[`CRFD_OPC_MSB:`CRFD_OPC_LSB];
  assign source_reg_field = instr_word[`CRFD_SRC_MSB:`CRFD_SRC_LSB];
  assign target_reg_field = instr_word[`CRFD_TGT_MSB:`CRFD_TGT_LSB];
  assign dest_reg_field = instr_word[`CRFD_DST_MSB:`CRFD_DST_LSB];
  assign shift_amount_field = instr_word[`CRFD_SHA_MSB:`CRFD_SHA_LSB];
  assign function_code = instr_word[`CRFD_FUN_MSB:`CRFD_FUN_LSB];

  assign imm_raw = instr_word[`CRFD_IMM_MSB:`CRFD_IMM_LSB];
  // Sign extended so one value serves operands, offsets and displacements
  assign imm_sext = {{16{imm_raw[15]}}, imm_raw};

  assign jump_index_field = instr_word[`CRFD_IDX_MSB:`CRFD_IDX_LSB];
  assign jump_low_addr = {jump_index_field, 2'h0};

endmodule // crfd_decode

`default_nettype wire

// ---- src/crfd_regfile.v ----
// Core register file: 32 general registers, multiply/divide pair and the
// hidden program counter, with registered instruction field decode.
// Assumes the pipeline presents commands synchronous to mclk, one per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "crfd_consts.vh"

module crfd_regfile #(
  parameter [31:0] PC_RESET = `CRFD_PC_RESET
) (
  input wire mclk,
  input wire sys_rst,
  input wire [31:0] instr_word,
  input wire [4:0] rd_a_addr,
  input wire [4:0] rd_b_addr,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [31:0] wr_data,
  input wire link_en,
  input wire [2:0] pc_ctl,
  input wire [31:0] pc_reg_target,
  input wire [31:0] branch_offset,
  input wire [3:0] md_op,
  input wire [31:0] md_op_a,
  input wire [31:0] md_op_b,
  output reg [5:0] opcode_q,
  output reg [4:0] source_reg_field_q,
  output reg [4:0] target_reg_field_q,
  output reg [4:0] dest_reg_field_q,
  output reg [4:0] shift_amount_field_q,
  output reg [5:0] function_code_q,
  output reg [31:0] imm_sext_q,
  output reg [31:0] jump_target_q,
  output reg [31:0] rd_a_data_q,
  output reg [31:0] rd_b_data_q,
  output reg [31:0] mul_div_high_q,
  output reg [31:0] mul_div_low_q,
  output reg [31:0] fetch_addr_q
);

  // ============================================================
  // Field decode
  wire [5:0] dec_opcode;
  wire [4:0] dec_src;
  wire [4:0] dec_tgt;
  wire [4:0] dec_dst;
  wire [4:0] dec_sha;
  wire [5:0] dec_fun;
  wire [31:0] dec_imm;
  wire [27:0] dec_jlow;

  crfd_decode u_decode (
    .instr_word(instr_word),
    .opcode(dec_opcode),
    .source_reg_field(dec_src),
    .target_reg_field(dec_tgt),
    .dest_reg_field(dec_dst),
    .shift_amount_field(dec_sha),
    .function_code(dec_fun),
    .imm_sext(dec_imm),
    .jump_low_addr(dec_jlow)
  );

  // ============================================================
  // Hidden program counter
  // Never reachable through the read or write ports; only pc_ctl moves it
  reg [31:0] pc_q;
  reg [31:0] pc_d;
  wire [31:0] pc_seq;
  wire [31:0] jump_target_d;

  assign pc_seq = pc_q + `CRFD_PC_STEP;
  // Upper four bits come from the current counter
  assign jump_target_d = {pc_q[31:28], dec_jlow};

  always @* begin
    case (pc_ctl)
      `CRFD_PC_HOLD: pc_d = pc_q;
      `CRFD_PC_SEQ: pc_d = pc_seq;
      `CRFD_PC_JUMP: pc_d = jump_target_d;
      `CRFD_PC_BRANCH: pc_d = pc_seq + {branch_offset[29:0], 2'h0};
      `CRFD_PC_REG: pc_d = pc_reg_target;
      default: pc_d = pc_q;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      pc_q <= PC_RESET;
      fetch_addr_q <= PC_RESET;
    end else begin
      pc_q <= pc_d;
      fetch_addr_q <= pc_d;
    end
  end

  // ============================================================
  // Single write port shared with the implicit link write
  // Link has priority: both in one cycle would need a second port
  reg eff_wr_en;
  reg [4:0] eff_wr_addr;
  reg [31:0] eff_wr_data;

  always @* begin
    if (link_en) begin
      eff_wr_en = 1'b1;
      eff_wr_addr = `CRFD_LINK_REG;
      // Return address skips the delay slot
      eff_wr_data = pc_q + `CRFD_LINK_OFS;
    end else begin
      eff_wr_en = wr_en;
      eff_wr_addr = wr_addr;
      eff_wr_data = wr_data;
    end
  end

  // ============================================================
  // General register bank; entry 0 has no storage at all
  reg [31:0] gpr_q [1:31];

  genvar gi;
  generate
    for (gi = 1; gi < 32; gi = gi + 1) begin : g_gpr
      always @(posedge mclk) begin
        if (sys_rst) begin
          gpr_q[gi] <= `CRFD_WORD_RESET;
        end else if (eff_wr_en && {27'h0000000, eff_wr_addr} == gi) begin
          gpr_q[gi] <= eff_wr_data;
        end
      end
    end
  endgenerate

  // Read with zero override and same-cycle write forwarding
  function [31:0] gpr_read;
    input [4:0] addr;
    begin
      if (addr == `CRFD_ZERO_REG) begin
        gpr_read = `CRFD_WORD_RESET;
      end else if (eff_wr_en && eff_wr_addr == addr) begin
        gpr_read = eff_wr_data;
      end else begin
        gpr_read = gpr_q[addr];
      end
    end
  endfunction

  always @(posedge mclk) begin
    if (sys_rst) begin
      rd_a_data_q <= `CRFD_WORD_RESET;
      rd_b_data_q <= `CRFD_WORD_RESET;
    end else begin
      rd_a_data_q <= gpr_read(rd_a_addr);
      rd_b_data_q <= gpr_read(rd_b_addr);
    end
  end

  // ============================================================
  // Multiply/divide pair
  wire [63:0] prod_s;
  wire [63:0] prod_u;
  wire [63:0] acc_now;
  reg [31:0] md_high_d;
  reg [31:0] md_low_d;

  // Operands widened to 64 bits first so the product keeps every bit
  assign prod_s = {{32{md_op_a[31]}}, md_op_a} * {{32{md_op_b[31]}}, md_op_b};
  assign prod_u = {32'h00000000, md_op_a} * {32'h00000000, md_op_b};
  assign acc_now = {mul_div_high_q, mul_div_low_q};

  // A zero divisor leaves the pair untouched rather than inventing a value
  always @* begin
    md_high_d = mul_div_high_q;
    md_low_d = mul_div_low_q;
    case (md_op)
      `CRFD_MD_NONE: begin
        md_high_d = mul_div_high_q;
      end
      `CRFD_MD_MULT: begin
        {md_high_d, md_low_d} = prod_s;
      end
      `CRFD_MD_MULTU: begin
        {md_high_d, md_low_d} = prod_u;
      end
      `CRFD_MD_MADD: begin
        {md_high_d, md_low_d} = acc_now + prod_s;
      end
      `CRFD_MD_MADDU: begin
        {md_high_d, md_low_d} = acc_now + prod_u;
      end
      `CRFD_MD_MSUB: begin
        {md_high_d, md_low_d} = acc_now - prod_s;
      end
      `CRFD_MD_MSUBU: begin
        {md_high_d, md_low_d} = acc_now - prod_u;
      end
      `CRFD_MD_DIV: begin
        if (md_op_b != 32'h00000000) begin
          md_low_d = $signed(md_op_a) / $signed(md_op_b);
          md_high_d = $signed(md_op_a) % $signed(md_op_b);
        end
      end
      `CRFD_MD_DIVU: begin
        if (md_op_b != 32'h00000000) begin
          md_low_d = md_op_a / md_op_b;
          md_high_d = md_op_a % md_op_b;
        end
      end
      default: begin
        md_high_d = mul_div_high_q;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      mul_div_high_q <= `CRFD_WORD_RESET;
      mul_div_low_q <= `CRFD_WORD_RESET;
    end else begin
      mul_div_high_q <= md_high_d;
      mul_div_low_q <= md_low_d;
    end
  end

  // ============================================================
  // Registered decode outputs
  always @(posedge mclk) begin
    if (sys_rst) begin
      opcode_q <= 6'h00;
      source_reg_field_q <= 5'h00;
      target_reg_field_q <= 5'h00;
      dest_reg_field_q <= 5'h00;
      shift_amount_field_q <= 5'h00;
      function_code_q <= 6'h00;
      imm_sext_q <= `CRFD_WORD_RESET;
      jump_target_q <= `CRFD_WORD_RESET;
    end else begin
      opcode_q <= dec_opcode;
      source_reg_field_q <= dec_src;
      target_reg_field_q <= dec_tgt;
      dest_reg_field_q <= dec_dst;
      shift_amount_field_q <= dec_sha;
      function_code_q <= dec_fun;
      imm_sext_q <= dec_imm;
      jump_target_q <= jump_target_d;
    end
  end

endmodule // crfd_regfile

`default_nettype wire

// ---- tb/crfd_monitor.sv ----
// Port checker for the core register file.
// Assumes the single clock mclk and synchronous reset sys_rst.
`timescale 1ns/1ns
`default_nettype none
module crfd_monitor (
  input wire mclk,
  input wire sys_rst,
  input wire [31:0] instr_word,
  input wire [4:0] rd_a_addr,
  input wire wr_en,
  input wire [4:0] wr_addr,
  input wire [31:0] wr_data,
  input wire link_en,
  input wire [2:0] pc_ctl,
  input wire [3:0] md_op,
  input wire [31:0] md_op_a,
  input wire [31:0] md_op_b,
  input wire [5:0] opcode_q,
  input wire [5:0] function_code_q,
  input wire [31:0] imm_sext_q,
  input wire [31:0] jump_target_q,
  input wire [31:0] rd_a_data_q,
  input wire [31:0] mul_div_high_q,
  input wire [31:0] mul_div_low_q,
  input wire [31:0] fetch_addr_q
);
  wire signed [63:0] prod_s = $signed(md_op_a) * $signed(md_op_b);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ============================================================
  // Sequences
  // Guard keeps $past from reaching into a reset cycle
  sequence s_run; !$past(sys_rst); endsequence
  sequence s_link; link_en && rd_a_addr == 5'h1F; endsequence
  sequence s_fwd;
    wr_en && !link_en && wr_addr != 5'h00 && wr_addr == rd_a_addr;
  endsequence
  // ============================================================
  // Assertions
  a_field_split: assert property (s_run |->
    opcode_q == $past(instr_word[31:26])
    && function_code_q == $past(instr_word[5:0])) else $error("fields");
  a_imm_sign: assert property (s_run |-> imm_sext_q ==
    {{16{$past(instr_word[15])}}, $past(instr_word[15:0])}) else $error("imm");
  a_jump_low: assert property (s_run |-> jump_target_q[27:0] ==
    {$past(instr_word[25:0]), 2'h0}) else $error("jump");
  a_zero_read: assert property (s_run ##0 $past(rd_a_addr) == 5'h00
    |-> rd_a_data_q == 32'h0) else $error("zero read");
  a_write_fwd: assert property (s_fwd |=>
    rd_a_data_q == $past(wr_data)) else $error("forward");
  a_link_ret: assert property (s_link |=>
    rd_a_data_q == $past(fetch_addr_q) + 32'h8) else $error("link");
  a_mult_prod: assert property (md_op == 4'h1 |=>
    {mul_div_high_q, mul_div_low_q} == $past(prod_s)) else $error("mult");
  a_pair_hold: assert property (md_op == 4'h0 |=>
    $stable(mul_div_high_q) && $stable(mul_div_low_q)) else $error("pair");
  a_pc_hold: assert property (pc_ctl == 3'h0 |=>
    $stable(fetch_addr_q)) else $error("pc hold");
  a_div_split: assert property (md_op == 4'h8 && md_op_b != 32'h0 |=>
    mul_div_low_q == $past(md_op_a) / $past(md_op_b)
    && mul_div_high_q == $past(md_op_a) % $past(md_op_b)) else $error("divide");
endmodule // crfd_monitor
bind crfd_regfile crfd_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst),
  .instr_word(instr_word), .rd_a_addr(rd_a_addr), .wr_en(wr_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .link_en(link_en),
  .pc_ctl(pc_ctl), .md_op(md_op), .md_op_a(md_op_a), .md_op_b(md_op_b),
  .opcode_q(opcode_q), .function_code_q(function_code_q),
  .imm_sext_q(imm_sext_q), .jump_target_q(jump_target_q),
  .rd_a_data_q(rd_a_data_q), .mul_div_high_q(mul_div_high_q),
  .mul_div_low_q(mul_div_low_q), .fetch_addr_q(fetch_addr_q));
`default_nettype wire

// ---- tb/crfd_pipe_model.sv ----
// Stand-in for the decode and execute stages: one command per edge.
// Assumes issue is called once per cycle, after reset release.
`timescale 1ns/1ns
`default_nettype none
module crfd_pipe_model (
  input wire mclk,
  output logic [31:0] instr_word,
  output logic [4:0] rd_a_addr,
  output logic [4:0] rd_b_addr,
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [31:0] wr_data,
  output logic link_en,
  output logic [2:0] pc_ctl,
  output logic [31:0] pc_reg_target,
  output logic [31:0] branch_offset,
  output logic [3:0] md_op,
  output logic [31:0] md_op_a,
  output logic [31:0] md_op_b
);
  // ============================================================
  // Command issue
  // Idle during reset so nothing is taken before release
  initial {instr_word, rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
    link_en, pc_ctl, pc_reg_target, branch_offset, md_op, md_op_a,
    md_op_b} = '0;
  task issue(input [31:0] iw, input [4:0] ra, rb, input we,
    input [4:0] wa, input [31:0] wd, input le, input [2:0] pc,
    input [31:0] tg, of, input [3:0] md, input [31:0] a, b);
    @(posedge mclk);
    {instr_word, rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data, link_en,
      pc_ctl, pc_reg_target, branch_offset, md_op, md_op_a, md_op_b} <=
      {iw, ra, rb, we, wa, wd, le, pc, tg, of, md, a, b};
    #1;
  endtask
endmodule // crfd_pipe_model
`default_nettype wire

// ---- tb/crfd_regfile_bench.sv ----
// Self-checking bench for the core register file.
// Assumes the pipeline stand-in issues commands and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module crfd_regfile_bench;
  logic mclk, sys_rst;
  wire [31:0] iw, wd, tg, of, a, b, imm, jmp, rda, rdb, mdh, mdl, pc;
  wire [4:0] ra, rb, wa, src, tgt, dst, sha;
  wire [5:0] opc, fun;
  wire [3:0] md;
  wire [2:0] pcc;
  wire we, le;
  int fails = 0, checked = 0;
  crfd_pipe_model pipe (.mclk(mclk), .instr_word(iw), .rd_a_addr(ra),
    .rd_b_addr(rb), .wr_en(we), .wr_addr(wa), .wr_data(wd), .link_en(le),
    .pc_ctl(pcc), .pc_reg_target(tg), .branch_offset(of), .md_op(md),
    .md_op_a(a), .md_op_b(b));
  crfd_regfile dut (.mclk(mclk), .sys_rst(sys_rst), .instr_word(iw),
    .rd_a_addr(ra), .rd_b_addr(rb), .wr_en(we), .wr_addr(wa), .wr_data(wd),
    .link_en(le), .pc_ctl(pcc), .pc_reg_target(tg), .branch_offset(of),
    .md_op(md), .md_op_a(a), .md_op_b(b), .opcode_q(opc),
    .source_reg_field_q(src), .target_reg_field_q(tgt),
    .dest_reg_field_q(dst), .shift_amount_field_q(sha),
    .function_code_q(fun), .imm_sext_q(imm), .jump_target_q(jmp),
    .rd_a_data_q(rda), .rd_b_data_q(rdb), .mul_div_high_q(mdh),
    .mul_div_low_q(mdl), .fetch_addr_q(pc));
  // ============================================================
  // Helpers
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input [4:0] x, y, input e, input [4:0] w, input [31:0] d,
    input l);
    pipe.issue(32'h0, x, y, e, w, d, l, 3'h0, 32'h0, 32'h0, 4'h0, 32'h0,
      32'h0);
  endtask
  task nop;
    wr(5'h00, 5'h00, 1'h0, 5'h00, 32'h0, 1'h0);
  endtask
  task pcx(input [31:0] w, input [2:0] c, input [31:0] t, o);
    pipe.issue(w, 5'h00, 5'h00, 1'h0, 5'h00, 32'h0, 1'h0, c, t, o, 4'h0,
      32'h0, 32'h0);
  endtask
  task m(input [3:0] op, input [31:0] x, y, input [63:0] exp);
    pipe.issue(32'h0, 5'h00, 5'h00, 1'h0, 5'h00, 32'h0, 1'h0, 3'h0, 32'h0,
      32'h0, op, x, y);
    nop;
    chk({mdh, mdl}, exp);
  endtask
  // ============================================================
  // Scenarios
  task t_decode;
    pcx({6'h23, 5'h04, 5'h05, 5'h1F, 5'h0A, 6'h2B}, 3'h0, 32'h0, 32'h0);
    nop;
    chk({opc, src, tgt, dst, sha, fun}, 32'h8C85FAAB);
    chk(imm, 32'hFFFFFAAB);
    chk(jmp, 32'h0217EAAC);
  endtask
  task t_regs;
    wr(5'h07, 5'h00, 1'h1, 5'h07, 32'h12345678, 1'h0);
    wr(5'h00, 5'h00, 1'h1, 5'h00, 32'hFFFFFFFF, 1'h0);
    chk(rda, 32'h12345678);
    nop;
    chk(rda, 32'h0);
    for (int i = 0; i < 32; i++)
      wr(5'h00, 5'h00, 1'h1, 5'(i), 32'hA5000000 + i, 1'h0);
    for (int i = 0; i < 33; i++) begin
      wr(5'(i), 5'h00, 1'h0, 5'h00, 32'h0, 1'h0);
      if (i > 0)
        chk(rda, (i == 1) ? 32'h0 : 32'hA4FFFFFF + i);
      chk(rdb, 32'h0);
    end
  endtask
  task t_pc;
    pcx(32'h0, 3'h1, 32'h0, 32'h0);
    pcx(32'h0, 3'h1, 32'h0, 32'h0);
    chk(pc, 32'h4);
    pcx(32'h0, 3'h3, 32'h0, 32'h10);
    chk(pc, 32'h8);
    pcx(32'h00000123, 3'h2, 32'h0, 32'h0);
    chk(pc, 32'h4C);
    pcx(32'h0, 3'h4, 32'hA0000010, 32'h0);
    chk(pc, 32'h48C);
    pcx(32'h03FFFFFF, 3'h2, 32'h0, 32'h0);
    chk(pc, 32'hA0000010);
    pcx(32'h0, 3'h3, 32'h0, 32'hFFFFFFFE);
    chk(pc, 32'hAFFFFFFC);
    nop;
    chk(pc, 32'hAFFFFFF8);
    nop;
    chk(pc, 32'hAFFFFFF8);
  endtask
  task t_link;
    // Link and an ordinary write together: link owns the write port
    wr(5'h1F, 5'h07, 1'h1, 5'h07, 32'hDEADBEEF, 1'h1);
    wr(5'h1F, 5'h07, 1'h0, 5'h00, 32'h0, 1'h0);
    chk(rda, 32'hB0000000);
    nop;
    chk({rda, rdb}, 64'hB0000000A5000007);
  endtask
  task t_muldiv;
    m(4'h1, 32'hFFFFFFFD, 32'h5, 64'hFFFFFFFFFFFFFFF1);
    m(4'h3, 32'h3, 32'h4, 64'hFFFFFFFFFFFFFFFD);
    m(4'h5, 32'h2, 32'h2, 64'hFFFFFFFFFFFFFFF9);
    m(4'h4, 32'hFFFFFFFF, 32'h1, 64'h00000000FFFFFFF8);
    m(4'h6, 32'h1, 32'h8, 64'h00000000FFFFFFF0);
    m(4'h2, 32'hFFFFFFFF, 32'h2, 64'h00000001FFFFFFFE);
    m(4'h7, 32'hFFFFFFF9, 32'h2, 64'hFFFFFFFFFFFFFFFD);
    m(4'h8, 32'h7, 32'h2, 64'h0000000100000003);
    m(4'h7, 32'h5, 32'h0, 64'h0000000100000003);
    m(4'h0, 32'h9, 32'h9, 64'h0000000100000003);
    m(4'hF, 32'h9, 32'h9, 64'h0000000100000003);
  endtask
  // ============================================================
  // Run control
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
  initial begin
    sys_rst = 1'h1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
    t_decode;
    t_regs;
    t_pc;
    t_link;
    t_muldiv;
    wrap_up;
  end
endmodule // crfd_regfile_bench
`default_nettype wire
